// ===== mfs_supervisor.sv
`timescale 1ns/1ps
// Summary of operation
// - no encoder movement latches stall fault 2,3 index 2231, five motor shutdowns
// - any open phase latches fault 2,4 index 2240, five motor shutdowns until power cycle
// - motor overcurrent latches type 2 fault 2,5 index 2241, variant option only
// - offset out of range 64 ms continuously latches fault 2,6 index 2832
// - open brake driver latches type 1 fault 3,1 index 2320, brake and throttle
// - shorted brake driver records the same fault as type 2
// - brake driver overcurrent records the same fault as type 3
// - encoder phase failure latches fault 2,3 index 2230, five motor shutdowns
module mfs_supervisor import mfs_pkg::*; #(
	parameter int OFFSET_CYCLES = OFFSET_CYC,
	parameter int ON_CYCLES = BLINK_ON_CYC,
	parameter int OFF_CYCLES = BLINK_OFF_CYC,
	parameter int PAUSE_CYCLES = BLINK_PAUSE_CYC,
	parameter bit OVERCURRENT_PRESENT = 1'b1
) (
	// clock and reset (reset follows the keyswitch)
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [AW-1:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// detection flags from the analog side
	input wire mfs_det_s det,
	// shutdown actions
	output mfs_act_s act,
	// fault report
	output logic fault_active,
	output mfs_rep_s report,
	// status indicator and interrupt
	output logic status_led,
	output logic irq
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// a zero count would wrap the window end to all ones, so the offset fault would almost never latch
	generate
		if (OFFSET_CYCLES < 1) begin : g_bad_offset
			$error("offset qualification must be at least one cycle");
		end
		// the blinker timers load count minus one, so zero would wrap
		if (ON_CYCLES < 1 || OFF_CYCLES < 1 || PAUSE_CYCLES < 1) begin : g_bad_blink
			$error("blink timings must be at least one cycle");
		end
		// every slot must fit the low bits of one register word
		if (NFLT > 32) begin : g_bad_slots
			$error("fault slots do not fit a register word");
		end
	endgenerate

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		mfs_det_s s1;
		mfs_det_s s2;
		logic [NFLT-1:0] latched;
		// registered copy of the any-fault summary, so the output is a flop
		logic fault;
		logic [1:0] brake_type;
		logic [31:0] off_cnt;
		logic [NFLT-1:0] irq_sts;
		logic [NFLT-1:0] irq_en;
		logic ind_en;
		logic [31:0] rd_data;
		mfs_act_s act;
		mfs_rep_s rep;
		logic irq;
	} mfs_st_s;

	mfs_st_s st_reg;
	mfs_st_s st_next;
	mfs_det_s d;
	logic [NFLT-1:0] cond;
	logic [NFLT-1:0] clr_mask;
	logic [31:0] off_last;

	// synchronised view of the pins
	assign d = st_reg.s2;
	assign off_last = 32'(OFFSET_CYCLES - 1);

	// ----------------------------------------
	// per-fault decoding
	// ----------------------------------------
	// shutdown set requested by one fault slot
	function automatic mfs_act_s fault_act(input int i);
		case (i)
			FLT_ENC: fault_act = ACT_MOTOR;
			FLT_STALL: fault_act = ACT_MOTOR;
			FLT_OPEN: fault_act = ACT_MOTOR;
			FLT_OC: fault_act = ACT_MOTOR;
			FLT_SENSE: fault_act = ACT_MOTOR;
			FLT_LIFT: fault_act = ACT_LIFT;
			FLT_BRAKE: fault_act = ACT_BRAKE;
			default: fault_act = ACT_NONE;
		endcase
	endfunction

	// flash code, type and index reported for one fault slot
	function automatic mfs_rep_s fault_rep(input int i, input logic [1:0] btype);
		case (i)
			FLT_ENC: fault_rep = '{DIG_2, DIG_3, FT_1, IDX_ENC};
			FLT_STALL: fault_rep = '{DIG_2, DIG_3, FT_1, IDX_STALL};
			FLT_OPEN: fault_rep = '{DIG_2, DIG_4, FT_1, IDX_OPEN};
			FLT_OC: fault_rep = '{DIG_2, DIG_5, FT_2, IDX_OC};
			FLT_SENSE: fault_rep = '{DIG_2, DIG_6, FT_1, IDX_SENSE};
			FLT_LIFT: fault_rep = '{DIG_2, DIG_7, FT_1, IDX_LIFT};
			FLT_BRAKE: fault_rep = '{DIG_3, DIG_1, btype, IDX_BRAKE};
			default: fault_rep = REP_NONE;
		endcase
	endfunction

	// ----------------------------------------
	// set conditions
	// ----------------------------------------
	always_comb begin
		cond = '0;
		cond[FLT_ENC] = d.encoder_fail;
		cond[FLT_STALL] = d.stall;
		cond[FLT_OPEN] = |d.phase_open;
		cond[FLT_OC] = d.motor_oc & OVERCURRENT_PRESENT;
		// only a reading bad for the whole window counts, glitches restart it
		cond[FLT_SENSE] = d.offset_bad && (st_reg.off_cnt == off_last);
		cond[FLT_LIFT] = d.lift_active & d.lift_expired;
		cond[FLT_BRAKE] = d.brake_open | d.brake_short | d.brake_oc;
	end

	// software clear of interrupt bits
	assign clr_mask = (wr_en && addr == REG_IRQ_CLR) ? wr_data[NFLT-1:0] : '0;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.s1 = det;
		st_next.s2 = st_reg.s1;

		// offset qualification counter, saturates at the window end
		if (!d.offset_bad) begin
			st_next.off_cnt = 32'h00000000;
		end else if (st_reg.off_cnt != off_last) begin
			st_next.off_cnt = st_reg.off_cnt + 32'h00000001;
		end

		// faults hold until reset, which only a keyswitch cycle gives
		st_next.latched = st_reg.latched | cond;
		// lift fault follows the lift input instead of latching
		st_next.latched[FLT_LIFT] = d.lift_active
			& (st_reg.latched[FLT_LIFT] | d.lift_expired);
		// summary flag follows the same edge as the slots themselves
		st_next.fault = |st_next.latched;

		// brake type is the first cause seen; open beats short beats overcurrent
		if (!st_reg.latched[FLT_BRAKE]) begin
			if (d.brake_open) begin
				st_next.brake_type = FT_1;
			end else if (d.brake_short) begin
				st_next.brake_type = FT_2;
			end else if (d.brake_oc) begin
				st_next.brake_type = FT_3;
			end
		end

		// actions are the OR over all active faults
		st_next.act = ACT_NONE;
		for (int i = 0; i < NFLT; i++) begin
			if (st_next.latched[i]) begin
				st_next.act = st_next.act | fault_act(i);
			end
		end

		// report walks down so the lowest slot wins
		st_next.rep = REP_NONE;
		for (int i = NFLT - 1; i >= 0; i--) begin
			if (st_next.latched[i]) begin
				st_next.rep = fault_rep(i, st_next.brake_type);
			end
		end

		// sticky interrupt bits, a new event wins over a clear in the same cycle
		// an event is a slot going active this cycle; computed here to avoid a false loop
		st_next.irq_sts = (st_reg.irq_sts & ~clr_mask)
			| (st_next.latched & ~st_reg.latched);
		st_next.irq = |(st_next.irq_sts & st_next.irq_en);

		// register writes
		if (wr_en) begin
			case (addr)
				REG_IRQ_EN: st_next.irq_en = wr_data[NFLT-1:0];
				REG_CTRL: st_next.ind_en = wr_data[0];
				default: st_next.irq_en = st_reg.irq_en;
			endcase
			st_next.irq = |(st_next.irq_sts & st_next.irq_en);
		end

		// register reads, data stands only in the following cycle
		st_next.rd_data = 32'h00000000;
		if (rd_en) begin
			case (addr)
				REG_FAULT: st_next.rd_data = 32'(st_reg.latched);
				REG_REPORT: st_next.rd_data = 32'(st_reg.rep);
				REG_IRQ_STS: st_next.rd_data = 32'(st_reg.irq_sts);
				REG_IRQ_EN: st_next.rd_data = 32'(st_reg.irq_en);
				REG_CTRL: st_next.rd_data = 32'(st_reg.ind_en);
				default: st_next.rd_data = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= '{
				s1: '0,
				s2: '0,
				latched: '0,
				fault: 1'b0,
				brake_type: FT_1,
				off_cnt: 32'h00000000,
				irq_sts: '0,
				irq_en: IRQ_EN_RST,
				ind_en: CTRL_IND_EN_RST,
				rd_data: 32'h00000000,
				act: ACT_NONE,
				rep: REP_NONE,
				irq: 1'b0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// indicator
	// ----------------------------------------
	// starts a burst only while a fault is held and software leaves it enabled; a burst under way runs out
	mfs_blinker #(
		.ON_CYCLES(ON_CYCLES),
		.OFF_CYCLES(OFF_CYCLES),
		.PAUSE_CYCLES(PAUSE_CYCLES)
	) u_blinker (
		.core_clk(core_clk),
		.rst(rst),
		.code_valid(st_reg.ind_en && st_reg.latched != '0),
		.digit_hi(st_reg.rep.flash_hi),
		.digit_lo(st_reg.rep.flash_lo),
		.led(status_led)
	);

	// outputs, all straight from the state register
	assign rd_data = st_reg.rd_data;
	assign act = st_reg.act;
	assign report = st_reg.rep;
	assign fault_active = st_reg.fault;
	assign irq = st_reg.irq;

endmodule

// ===== mfs_pkg.sv
package mfs_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	// zero-point reading must stay bad this long before the fault latches
	localparam int OFFSET_TIME_MS = 64;
	localparam int OFFSET_CYC = OFFSET_TIME_MS * CLK_PER_MS;
	// indicator blink timing
	localparam int BLINK_ON_MS = 250;
	localparam int BLINK_OFF_MS = 250;
	localparam int BLINK_PAUSE_MS = 1000;
	localparam int BLINK_ON_CYC = BLINK_ON_MS * CLK_PER_MS;
	localparam int BLINK_OFF_CYC = BLINK_OFF_MS * CLK_PER_MS;
	localparam int BLINK_PAUSE_CYC = BLINK_PAUSE_MS * CLK_PER_MS;

	// ----------------------------------------
	// fault slots, lowest number has highest priority
	// ----------------------------------------
	localparam int NFLT = 7;
	localparam int FLT_ENC = 0;
	localparam int FLT_STALL = 1;
	localparam int FLT_OPEN = 2;
	localparam int FLT_OC = 3;
	localparam int FLT_SENSE = 4;
	localparam int FLT_LIFT = 5;
	localparam int FLT_BRAKE = 6;

	// bus fault indices
	localparam logic [15:0] IDX_ENC = 16'h2230;
	localparam logic [15:0] IDX_STALL = 16'h2231;
	localparam logic [15:0] IDX_OPEN = 16'h2240;
	localparam logic [15:0] IDX_OC = 16'h2241;
	localparam logic [15:0] IDX_SENSE = 16'h2832;
	localparam logic [15:0] IDX_LIFT = 16'h2232;
	localparam logic [15:0] IDX_BRAKE = 16'h2320;

	// flash code digits
	localparam logic [3:0] DIG_2 = 4'h2;
	localparam logic [3:0] DIG_3 = 4'h3;
	localparam logic [3:0] DIG_4 = 4'h4;
	localparam logic [3:0] DIG_5 = 4'h5;
	localparam logic [3:0] DIG_6 = 4'h6;
	localparam logic [3:0] DIG_7 = 4'h7;
	localparam logic [3:0] DIG_1 = 4'h1;

	// fault types
	localparam logic [1:0] FT_1 = 2'h1;
	localparam logic [1:0] FT_2 = 2'h2;
	localparam logic [1:0] FT_3 = 2'h3;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int AW = 8;
	localparam logic [AW-1:0] REG_FAULT = 8'h00;
	localparam logic [AW-1:0] REG_REPORT = 8'h04;
	localparam logic [AW-1:0] REG_IRQ_STS = 8'h08;
	localparam logic [AW-1:0] REG_IRQ_CLR = 8'h0C;
	localparam logic [AW-1:0] REG_IRQ_EN = 8'h10;
	localparam logic [AW-1:0] REG_CTRL = 8'h14;
	localparam logic CTRL_IND_EN_RST = 1'h1;
	localparam logic [NFLT-1:0] IRQ_EN_RST = 7'h00;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic lift;
		logic interlock;
		logic throttle;
		logic brake;
		logic contactor;
		logic bridge;
	} mfs_act_s;

	localparam mfs_act_s ACT_NONE = 6'h00;
	localparam mfs_act_s ACT_MOTOR = 6'h1F;
	localparam mfs_act_s ACT_BRAKE = 6'h0C;
	localparam mfs_act_s ACT_LIFT = 6'h20;

	typedef struct packed {
		logic [3:0] flash_hi;
		logic [3:0] flash_lo;
		logic [1:0] ftype;
		logic [15:0] index;
	} mfs_rep_s;

	localparam mfs_rep_s REP_NONE = 26'h0000000;

	typedef struct packed {
		logic encoder_fail;
		logic stall;
		logic [2:0] phase_open;
		logic motor_oc;
		logic offset_bad;
		logic lift_active;
		logic lift_expired;
		logic brake_open;
		logic brake_short;
		logic brake_oc;
	} mfs_det_s;

	typedef enum logic [3:0] {
		BL_IDLE = 4'h1,
		BL_ON = 4'h2,
		BL_OFF = 4'h4,
		BL_GAP = 4'h8
	} mfs_blink_e;

endpackage

// ===== mfs_blinker.sv
`timescale 1ns/1ps
module mfs_blinker import mfs_pkg::*; #(
	parameter int ON_CYCLES = BLINK_ON_CYC,
	parameter int OFF_CYCLES = BLINK_OFF_CYC,
	parameter int PAUSE_CYCLES = BLINK_PAUSE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// code to show
	input wire logic code_valid,
	input wire logic [3:0] digit_hi,
	input wire logic [3:0] digit_lo,
	// indicator
	output logic led
);

	generate
		if (ON_CYCLES < 1 || OFF_CYCLES < 1 || PAUSE_CYCLES < 1) begin : g_bad
			$error("blink timings must be at least one cycle");
		end
	endgenerate

	typedef struct packed {
		mfs_blink_e state;
		logic [31:0] tmr;
		logic [3:0] cnt;
		logic second;
		logic led;
	} mfs_blink_st_s;

	mfs_blink_st_s st_reg;
	mfs_blink_st_s st_next;

	// burst of first digit, pause, burst of second digit, pause, repeat
	always_comb begin
		st_next = st_reg;
		if (st_reg.tmr != 32'h00000000) begin
			st_next.tmr = st_reg.tmr - 32'h00000001;
		end
		case (st_reg.state)
			BL_IDLE: begin
				st_next.led = 1'b0;
				if (code_valid && digit_hi != 4'h0) begin
					st_next.state = BL_ON;
					st_next.tmr = 32'(ON_CYCLES - 1);
					st_next.cnt = digit_hi;
					st_next.second = 1'b0;
					st_next.led = 1'b1;
				end
			end
			BL_ON: begin
				if (st_reg.tmr == 32'h00000000) begin
					st_next.state = BL_OFF;
					st_next.tmr = 32'(OFF_CYCLES - 1);
					st_next.cnt = st_reg.cnt - 4'h1;
					st_next.led = 1'b0;
				end
			end
			BL_OFF: begin
				if (st_reg.tmr == 32'h00000000) begin
					if (st_reg.cnt != 4'h0) begin
						st_next.state = BL_ON;
						st_next.tmr = 32'(ON_CYCLES - 1);
						st_next.led = 1'b1;
					end else begin
						st_next.state = BL_GAP;
						st_next.tmr = 32'(PAUSE_CYCLES - 1);
					end
				end
			end
			BL_GAP: begin
				// the code is re-read here, so a new top fault shows on the next burst
				if (st_reg.tmr == 32'h00000000) begin
					if (!st_reg.second && code_valid && digit_lo != 4'h0) begin
						st_next.state = BL_ON;
						st_next.tmr = 32'(ON_CYCLES - 1);
						st_next.cnt = digit_lo;
						st_next.second = 1'b1;
						st_next.led = 1'b1;
					end else begin
						st_next.state = BL_IDLE;
					end
				end
			end
			default: begin
				st_next.state = BL_IDLE;
				st_next.led = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= '{state: BL_IDLE, tmr: 32'h00000000, cnt: 4'h0, second: 1'b0, led: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign led = st_reg.led;

endmodule

// ===== mfs_checker.sv
`timescale 1ns/1ps
module mfs_checker import mfs_pkg::*; #(
	parameter int OFFSET_CYCLES = OFFSET_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [AW-1:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rd_data,
	// detection and results
	input wire mfs_det_s det,
	input wire mfs_act_s act,
	input wire logic fault_active,
	input wire mfs_rep_s report,
	input wire logic status_led,
	input wire logic irq
);
	// ----
	// offset run tracking
	// ----
	int run_reg, run_next;
	logic seen_reg, seen_next;
	// raw flags lead the synced copy, so the early bound is loose
	always_comb begin
		run_next = det.offset_bad ? run_reg + 1 : 0;
		seen_next = seen_reg | (run_reg >= OFFSET_CYCLES - 1);
	end
	// run counter register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			run_reg <= 0;
			seen_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			seen_reg <= seen_next;
		end
	end
	// ----
	// properties
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	stall_shut_a: assert property (det.stall |-> ##[1:4] (act & ACT_MOTOR) == ACT_MOTOR)
		else $error("stall did not shut the motor path");
	open_shut_a: assert property (|det.phase_open |-> ##[1:4] (act & ACT_MOTOR) == ACT_MOTOR)
		else $error("open phase did not shut the motor path");
	bridge_hold_a: assert property (act.bridge |=> act.bridge)
		else $error("bridge shutdown released without reset");
	lift_set_a: assert property (det.lift_active && det.lift_expired |-> ##[1:4] act.lift)
		else $error("lift timeout did not stop the lift");
	lift_clear_a: assert property ((!det.lift_active) [*6] |-> !act.lift)
		else $error("lift shutdown held after lift dropped");
	brake_act_a: assert property (det.brake_open || det.brake_short || det.brake_oc
		|-> ##[1:4] act.brake && act.throttle) else $error("brake fault actions missing");
	enc_rep_a: assert property (det.encoder_fail |-> ##[1:5] report.index == IDX_ENC)
		else $error("encoder fault not reported first");
	sense_early_a: assert property (report.index == IDX_SENSE |-> seen_reg)
		else $error("offset fault latched too early");
	sense_late_a: assert property (run_reg == OFFSET_CYCLES + 6 |-> fault_active)
		else $error("offset fault latched too late");
	// main scenarios
	cover property ($rose(act.bridge));
	cover property ($fell(act.lift));
	cover property ($rose(irq));
endmodule

bind mfs_supervisor mfs_checker #(.OFFSET_CYCLES(OFFSET_CYCLES)) u_chk (.core_clk(core_clk),
	.rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .det(det), .act(act), .fault_active(fault_active),
	.report(report), .status_led(status_led), .irq(irq));

// ===== mfs_plant.sv
`timescale 1ns/1ps
module mfs_plant import mfs_pkg::*; (
	// clock
	input wire logic core_clk,
	// conditions the bench wants present
	input wire mfs_det_s inj,
	// detector flags toward the supervisor
	output mfs_det_s det
);
	// detectors settle one clock after the condition; no glitch filter
	always_ff @(posedge core_clk) begin
		det <= inj;
	end
endmodule

// ===== motor_fault_supervisor_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module motor_fault_supervisor_test import mfs_pkg::*; ;
	// clock, reset and register port
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [AW-1:0] addr = '0;
	logic [31:0] wr_data = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data;
	// detector path and results
	mfs_det_s inj = '0;
	mfs_det_s det;
	mfs_act_s act;
	mfs_act_s ea;
	mfs_rep_s report;
	logic fault_active, status_led, irq, was, any;
	logic rd_v = 1'b0;
	// scoreboard state
	int err_total = 0;
	int n_checks = 0;
	int k, nb, lo;
	int bq[$];
	logic [31:0] exp_q[$];
	logic [31:0] ex;
	logic [31:0] seed = 32'h22EE;
	// single-condition table: flags, slot, expected report
	logic [11:0] tdet [9] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040,
		12'h004, 12'h002, 12'h001};
	int tslot [9] = '{0, 1, 2, 2, 2, 3, 6, 6, 6};
	mfs_rep_s trep [9] = '{{DIG_2, DIG_3, FT_1, IDX_ENC}, {DIG_2, DIG_3, FT_1, IDX_STALL},
		{DIG_2, DIG_4, FT_1, IDX_OPEN}, {DIG_2, DIG_4, FT_1, IDX_OPEN},
		{DIG_2, DIG_4, FT_1, IDX_OPEN}, {DIG_2, DIG_5, FT_2, IDX_OC},
		{DIG_3, DIG_1, FT_1, IDX_BRAKE}, {DIG_3, DIG_1, FT_2, IDX_BRAKE},
		{DIG_3, DIG_1, FT_3, IDX_BRAKE}};

	// clock generator
	always #4 core_clk = ~core_clk;

	mfs_plant u_plant (.core_clk(core_clk), .inj(inj), .det(det));
	mfs_supervisor #(.OFFSET_CYCLES(8), .ON_CYCLES(3), .OFF_CYCLES(3), .PAUSE_CYCLES(6),
		.OVERCURRENT_PRESENT(1'b1)) dut (.core_clk(core_clk), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .det(det),
		.act(act), .fault_active(fault_active), .report(report),
		.status_led(status_led), .irq(irq));

	// ----
	// bus and run helpers
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// trailing idle edge keeps a strobe from being driven twice in one step
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		cyc(1);
		wr_en <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		rd_en <= 1'b1;
		addr <= a;
		cyc(1);
		rd_en <= 1'b0;
		cyc(1);
	endtask
	// keyswitch cycle
	task automatic rstp();
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// read data matched in order against noted expectations; idle reads give 0
	always @(posedge core_clk) begin
		if (rd_v) begin
			ex = exp_q.pop_front();
			`CHK(rd_data, ex)
		end else if (!rst) begin
			`CHK(rd_data, 32'h0)
		end
		rd_v <= rd_en;
	end

	// ----
	// main sequence
	// ----
	initial begin
		cyc(12);
		rst <= 1'b0;
		cyc(1);
		// reset values, unmapped and read-only places, random enable pattern
		rd(REG_CTRL, 32'h1);
		rd(8'h1C, 32'h0);
		seed = lfsr(seed);
		wr(REG_FAULT, seed);
		wr(REG_IRQ_EN, seed);
		rd(REG_FAULT, 32'h0);
		rd(REG_IRQ_EN, {25'h0, seed[6:0]});
		wr(REG_IRQ_EN, 32'h0);
		// each condition: latch, relatch across reset, hold after removal
		for (int i = 0; i < 9; i++) begin
			ea = (i < 6) ? ACT_MOTOR : ACT_BRAKE;
			inj <= tdet[i];
			cyc(6);
			`CHK(act, ea)
			`CHK(report, trep[i])
			rd(REG_FAULT, 32'h1 << tslot[i]);
			rd(REG_REPORT, {6'h0, trep[i]});
			rstp();
			cyc(5);
			`CHK(act, ea)
			inj <= '0;
			cyc(6);
			`CHK(act, ea)
			rstp();
			cyc(5);
			`CHK(act, ACT_NONE)
		end
		// short bad offset ignored, long one latches within a bound
		inj <= 12'h020;
		cyc(5);
		inj <= '0;
		cyc(12);
		`CHK(fault_active, 1'b0)
		inj <= 12'h020;
		k = 0;
		while (fault_active !== 1'b1 && k < 40) begin
			cyc(1);
			k++;
		end
		if (k == 40) begin
			err_total++;
			wrap_up();
		end
		`CHK(k >= 10 && k <= 14, 1'b1)
		cyc(2);
		`CHK(act, ACT_MOTOR)
		`CHK(report, {DIG_2, DIG_6, FT_1, IDX_SENSE})
		inj <= '0;
		rstp();
		// lift timeout: lift only, held while active, gone without reset
		inj <= 12'h018;
		cyc(6);
		`CHK(act, ACT_LIFT)
		`CHK(report, {DIG_2, DIG_7, FT_1, IDX_LIFT})
		inj <= 12'h010;
		cyc(6);
		`CHK(act, ACT_LIFT)
		inj <= '0;
		cyc(6);
		`CHK(act, ACT_NONE)
		// several faults: actions merge, priority picks the report
		inj <= 12'h01C;
		cyc(6);
		`CHK(act, ACT_LIFT | ACT_BRAKE)
		`CHK(report, {DIG_2, DIG_7, FT_1, IDX_LIFT})
		inj <= 12'h404;
		cyc(8);
		`CHK(act, ACT_MOTOR)
		`CHK(report, trep[1])
		inj <= '0;
		rstp();
		// interrupt: masked, enabled, cleared
		inj <= 12'h400;
		cyc(6);
		`CHK(irq, 1'b0)
		rd(REG_IRQ_STS, 32'h2);
		wr(REG_IRQ_EN, 32'h2);
		cyc(2);
		`CHK(irq, 1'b1)
		wr(REG_IRQ_CLR, 32'h2);
		cyc(2);
		`CHK(irq, 1'b0)
		rd(REG_IRQ_STS, 32'h0);
		// indicator bursts for code 2,3 from a fresh latch
		inj <= '0;
		rstp();
		inj <= 12'h400;
		nb = 0;
		lo = 0;
		was = 1'b0;
		for (int j = 0; j < 110; j++) begin
			cyc(1);
			if (status_led === 1'b1 && !was) nb++;
			lo = (status_led === 1'b1) ? 0 : lo + 1;
			if (lo == 5 && nb > 0) begin
				bq.push_back(nb);
				nb = 0;
			end
			was = (status_led === 1'b1);
		end
		`CHK(bq[0], 2)
		`CHK(bq[1], 3)
		`CHK(bq[2], 2)
		// disable the lamp and read the control bit back
		wr(REG_CTRL, 32'h0);
		rd(REG_CTRL, 32'h0);
		// a burst already under way runs to its end before the lamp rests
		cyc(30);
		any = 1'b0;
		for (int j = 0; j < 40; j++) begin
			cyc(1);
			any |= (status_led !== 1'b0);
		end
		`CHK(any, 1'b0)
		cyc(4);
		wrap_up();
	end
endmodule
